// >>> tb/cpu_core_model.sv
// Behavioural CPU core that enters and leaves handlers on request.
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic hclk,       // System clock.
  input  wire logic hresetn,    // Reset, active low.
  input  wire logic irq_high,   // High request.
  input  wire logic irq_low,    // Low request.
  input  wire logic allow,      // Bench lets the core take requests.
  input  wire logic leave,      // Bench asks for a return.
  output logic      enter_high, // High entry pulse.
  output logic      enter_low,  // Low entry pulse.
  output logic      ret         // Return pulse.
);
  logic [1:0] depth; // 0 main, 1 low, 2 high over main, 3 high over low.

  // A high request preempts main or low; a low one only main.
  wire take_high = allow && irq_high && !depth[1];
  wire take_low  = allow && irq_low && !irq_high && (depth == 2'd0);
  wire go_back   = leave && (depth != 2'd0) && !take_high && !take_low;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      depth <= 2'd0;
      enter_high <= 1'b0;
      enter_low <= 1'b0;
      ret <= 1'b0;
    end else begin
      enter_high <= take_high;
      enter_low <= take_low;
      ret <= go_back;
      if (take_high)
        depth <= depth[0] ? 2'd3 : 2'd2;
      else if (take_low)
        depth <= 2'd1;
      else if (go_back)
        depth <= (depth == 2'd3) ? 2'd1 : 2'd0;
    end
  end
endmodule : cpu_core_model

// >>> tb/intc_global_props.sv
// Checker of bus timing and core request outputs of the interrupt block.
`timescale 1ns/1ps
module intc_global_props
  import intc_global_pkg::*;
(
  input wire logic             hclk,            // System clock.
  input wire logic             hresetn,         // Reset, active low.
  input wire logic             clk_en,          // Clock enable.
  input wire logic             hsel,            // Slave select.
  input wire logic [1:0]       htrans,          // Transfer type.
  input wire logic             hwrite,          // Write strobe.
  input wire logic             hready,          // Bus ready.
  input wire logic             hreadyout,       // Slave ready.
  input wire logic             hresp,           // Slave response.
  input wire logic             vector_table_on, // Vector table strap.
  input wire logic             sleep_mode,      // Core asleep.
  input wire logic             cpu_irq_high,    // High request.
  input wire logic             cpu_irq_low,     // Low request.
  input wire logic [SRC_W-1:0] vector_number,   // Chosen source.
  input wire logic [VT_W-1:0]  vector_entry,    // Branch address.
  input wire logic             wake_request     // Wake request.
);
  // All properties share the bus clock and its reset.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // A transfer is taken when selected, active and ready.
  wire taken = hsel && htrans[1] && hready && clk_en;

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  a_write_nowait: assert property (taken && hwrite |=> hreadyout ##1 (hreadyout || $past(taken && !hwrite)))
    else $error("write stalled the bus");
  a_legacy_vector: assert property (!vector_table_on && cpu_irq_high |-> vector_entry == 24'h000008)
    else $error("legacy high request not at fixed vector");
  a_low_excl: assert property (cpu_irq_low |-> !cpu_irq_high)
    else $error("low request beside high request");
  a_wake_follows: assert property (cpu_irq_high && !sleep_mode |-> wake_request)
    else $error("request without wake");
  a_entry_even: assert property (vector_table_on && cpu_irq_high |-> vector_entry[0] == 1'b0)
    else $error("table entry odd");
  a_source_range: assert property ($rose(cpu_irq_high) |-> vector_number <= 4'ha)
    else $error("source number out of range");
endmodule : intc_global_props

bind interrupt_global_control_status intc_global_props props_u (.hclk, .hresetn, .clk_en,
  .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .vector_table_on, .sleep_mode,
  .cpu_irq_high, .cpu_irq_low, .vector_number, .vector_entry, .wake_request);

// >>> tb/tb_interrupt_global_control_status.sv
// Self-checking bench of the interrupt global control and status block.
`timescale 1ns/1ps
module tb_interrupt_global_control_status;
  import intc_global_pkg::*;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, vector_table_on;
  logic        sleep_mode, cpu_enter_high, cpu_enter_low, cpu_return, allow, leave;
  logic        cpu_irq_high, cpu_irq_low, wake_request, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ext_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [6:1]  sys_event;
  logic [7:0]  pin_change_bits;
  logic [3:0]  vector_number;
  logic [23:0] vector_entry;
  int          num_errors = 0;
  int          compares = 0;

  interrupt_global_control_status dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .vector_table_on, .ext_pin, .sys_event, .pin_change_bits, .cpu_enter_high,
    .cpu_enter_low, .cpu_return, .sleep_mode, .cpu_irq_high, .cpu_irq_low,
    .vector_number, .vector_entry, .wake_request, .irq);
  cpu_core_model core_u (.hclk, .hresetn, .irq_high(cpu_irq_high), .irq_low(cpu_irq_low),
    .allow, .leave, .enter_high(cpu_enter_high), .enter_low(cpu_enter_low), .ret(cpu_return));

  // Clock of 40 ns period.
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;

  task automatic summarize();
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic do_reset(input logic vt);
    hresetn <= 1'b0;
    vector_table_on <= vt;
    tick(6);
    hresetn <= 1'b1;
    tick(1);
  endtask : do_reset

  // One single AHB transfer; the master waits on the slave's ready.
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    htrans <= 2'b10;
    haddr <= {24'h000000, ofs};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
    logic [31:0] unused;
    bus(1'b1, ofs, data, unused);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] seen;
    bus(1'b0, ofs, 32'h00000000, seen);
    check(what, seen, exp);
  endtask : rd

  task automatic fire(input logic [6:1] ev);
    sys_event <= ev;
    tick(1);
    sys_event <= 6'h00;
    tick(4);
  endtask : fire

  task automatic step_back();
    leave <= 1'b1;
    tick(1);
    leave <= 1'b0;
    tick(3);
  endtask : step_back

  task automatic test_reset_map();
    rd("control", OFS_GLOBAL_CONTROL, 32'h07);
    rd("base", OFS_VECTOR_BASE, 32'h000008);
    rd("unmapped", 8'h3c, 32'h0);
    wr(OFS_GLOBAL_CONTROL, 32'hff);
    rd("control all", OFS_GLOBAL_CONTROL, 32'he7);
    wr(OFS_GLOBAL_CONTROL, 32'hc0);
    rd("low bit", OFS_GLOBAL_CONTROL, 32'h80);
    wr(OFS_HANDLER_STATE, 32'hc0);
    rd("state", OFS_HANDLER_STATE, 32'h00);
  endtask : test_reset_map

  task automatic test_flags();
    fire(6'h3f);
    rd("hw flags", OFS_SYSTEM_FLAGS, 32'h7e);
    wr(OFS_SYSTEM_FLAGS, 32'hff);
    rd("sw flags", OFS_SYSTEM_FLAGS, 32'h7f);
    wr(OFS_SYSTEM_FLAGS, 32'h00);
    pin_change_bits <= 8'h10;
    rd("summary set", OFS_SYSTEM_FLAGS, 32'h80);
    pin_change_bits <= 8'h00;
    tick(2);
    rd("summary clear", OFS_SYSTEM_FLAGS, 32'h00);
  endtask : test_flags

  task automatic test_legacy_high();
    wr(OFS_GLOBAL_CONTROL, 32'h00);
    wr(OFS_SOURCE_ENABLE, 32'h001);
    wr(OFS_SYSTEM_FLAGS, 32'h01);
    tick(4);
    check("blocked", cpu_irq_high, 1'b0);
    wr(OFS_GLOBAL_CONTROL, 32'h80);
    tick(3);
    check("high req", cpu_irq_high, 1'b1);
    check("fixed entry", vector_entry, 24'h000008);
    allow <= 1'b1;
    tick(4);
    rd("in high", OFS_HANDLER_STATE, 32'h80);
    wr(OFS_SYSTEM_FLAGS, 32'h00);
    step_back();
    rd("back main", OFS_HANDLER_STATE, 32'h00);
  endtask : test_legacy_high

  task automatic test_priority();
    allow <= 1'b0;
    wr(OFS_SOURCE_PRIORITY, 32'h7fe);
    wr(OFS_SOURCE_ENABLE, 32'h003);
    wr(OFS_GLOBAL_CONTROL, 32'h60);
    wr(OFS_SYSTEM_FLAGS, 32'h01);
    tick(3);
    check("low gated", cpu_irq_low, 1'b0);
    wr(OFS_GLOBAL_CONTROL, 32'he0);
    tick(3);
    check("low req", cpu_irq_low, 1'b1);
    check("low entry", vector_entry, LEGACY_LOW_VEC);
    allow <= 1'b1;
    tick(4);
    rd("in low", OFS_HANDLER_STATE, 32'h40);
    fire(6'h01);
    rd("high over low", OFS_HANDLER_STATE, 32'hc0);
    wr(OFS_SYSTEM_FLAGS, 32'h00);
    step_back();
    rd("low again", OFS_HANDLER_STATE, 32'h40);
    step_back();
  endtask : test_priority

  task automatic test_ext_pins();
    wr(OFS_GLOBAL_CONTROL, 32'h00);
    ext_pin <= 3'b001;
    tick(6);
    rd("rise ignored", OFS_EXT_PIN_FLAGS, 32'h0);
    ext_pin <= 3'b000;
    tick(6);
    rd("fall taken", OFS_EXT_PIN_FLAGS, 32'h1);
    wr(OFS_GLOBAL_CONTROL, 32'h07);
    ext_pin <= 3'b010;
    tick(6);
    rd("rise taken", OFS_EXT_PIN_FLAGS, 32'h3);
  endtask : test_ext_pins

  task automatic test_wake_irq();
    wr(OFS_SOURCE_ENABLE, 32'h008);
    sleep_mode <= 1'b1;
    fire(6'h04);
    check("asleep", wake_request, 1'b0);
    sleep_mode <= 1'b0;
    tick(3);
    check("wake", wake_request, 1'b1);
    wr(OFS_IRQ_CLEAR, 32'hf);
    wr(OFS_IRQ_ENABLE, 32'h1);
    fire(6'h20);
    check("irq on", irq, 1'b1);
    rd("status", OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h1);
    tick(2);
    check("irq off", irq, 1'b0);
    rd("clear reg", OFS_IRQ_CLEAR, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h0);
    fire(6'h20);
    check("irq masked", irq, 1'b0);
  endtask : test_wake_irq

  task automatic test_vector_table();
    allow <= 1'b0;
    ext_pin <= 3'b000;
    do_reset(1'b1);
    wr(OFS_VECTOR_BASE, 32'h004008);
    wr(OFS_SOURCE_ENABLE, 32'h002);
    wr(OFS_GLOBAL_CONTROL, 32'h80);
    fire(6'h01);
    check("table entry", vector_entry, 24'h00400a);
    check("source", vector_number, 4'h1);
  endtask : test_vector_table

  // Main sequence.
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, vector_table_on} = '0;
    {sleep_mode, allow, leave, ext_pin, sys_event, pin_change_bits} = '0;
    hsel = 1'b1;
    clk_en = 1'b1;
    hsize = 3'h2;
    do_reset(1'b0);
    test_reset_map();
    test_flags();
    test_legacy_high();
    test_priority();
    test_ext_pins();
    test_wake_irq();
    test_vector_table();
    summarize();
  end

  // Cuts a hung run short.
  initial begin
    tick(20000);
    num_errors++;
    summarize();
  end
endmodule : tb_interrupt_global_control_status

// >>> verilog/intc_global_pkg.sv
// Package with register map, field layout, reset values and types of the interrupt block.
package intc_global_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_GLOBAL_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_HANDLER_STATE   = 8'h04;
  localparam logic [7:0] OFS_SYSTEM_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_SOURCE_ENABLE   = 8'h0c;
  localparam logic [7:0] OFS_SOURCE_PRIORITY = 8'h10;
  localparam logic [7:0] OFS_EXT_PIN_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_VECTOR_BASE     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS      = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLEAR       = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE      = 8'h24;

  // Global control fields.
  localparam int         GC_HIGH_EN_BIT = 7;
  localparam int         GC_LOW_EN_BIT  = 6;
  localparam int         GC_PRIO_BIT    = 5;
  localparam int         GC_EDGE_LSB    = 0;
  localparam logic [7:0] GC_RESET       = 8'h07;
  localparam logic [7:0] GC_WRITE_MASK  = 8'he7;

  // Handler state field position.
  localparam int HS_FIELD_LSB = 6;

  // System event flag fields.
  localparam int         SEF_SUMMARY_BIT = 7;
  localparam int         SEF_CLKSW_BIT   = 3;
  localparam int         SEF_SOFT_BIT    = 0;
  localparam logic [7:0] SEF_HW_MASK     = 8'h7e;
  localparam logic [7:0] SEF_WRITE_MASK  = 8'h7f;
  localparam logic [7:0] SEF_RESET       = 8'h00;

  // Interrupt sources: system flags 0..7, external pins 8..10.
  localparam int          NUM_EXT     = 3;
  localparam int          NUM_SRC     = 11;
  localparam int          SRC_W       = 4;
  localparam logic [10:0] PRIO_RESET  = 11'h7ff;
  localparam logic [10:0] ENA_RESET   = 11'h000;

  // Vector addressing.
  localparam int          VT_W            = 24;
  localparam logic [23:0] VT_RESET        = 24'h000008;
  localparam logic [23:0] FIXED_VECTOR    = 24'h000008;
  localparam logic [23:0] LEGACY_LOW_VEC  = 24'h000018;

  // Block event status bits.
  localparam int         IRQ_W        = 4;
  localparam int         EV_FLAG_SET  = 0;
  localparam int         EV_PIN_EDGE  = 1;
  localparam int         EV_HIGH_TAKE = 2;
  localparam int         EV_LOW_TAKE  = 3;

  // Handler states, one-hot.
  typedef enum logic [3:0] {
    ST_MAIN      = 4'b0001,
    ST_LOW       = 4'b0010,
    ST_HIGH_MAIN = 4'b0100,
    ST_HIGH_LOW  = 4'b1000
  } handler_state_type;

  // Codes read back for each handler state.
  localparam logic [1:0] CODE_MAIN      = 2'h0;
  localparam logic [1:0] CODE_LOW       = 2'h1;
  localparam logic [1:0] CODE_HIGH_MAIN = 2'h2;
  localparam logic [1:0] CODE_HIGH_LOW  = 2'h3;

  // Captured AHB address phase.
  typedef struct packed {
    logic       write;
    logic [7:0] offset;
  } bus_phase_type;

  // Request handed to the CPU core.
  typedef struct packed {
    logic             high;
    logic             low;
    logic [3:0]       source;
    logic [23:0]      entry;
  } cpu_request_type;

endpackage : intc_global_pkg

// >>> verilog/interrupt_global_control_status.sv
// Global control, handler state and system event flags of the vectored interrupt controller.
//
// Function
// - Vector table off: no table lookup; per-source priority still honoured when priority is on.
// - Table and priority both off: every request goes to address 0008h.
// - Vector base resets to 0x000008 and software may rewrite it.
// - Priority off: bit 7 set allows unmasked interrupts, clear blocks all.
// - Priority on: bit 7 is high enable, also needed for low interrupts.
// - Bit 6 reads zero with priority off; else enables low with bit 7.
// - Priority on honours per-source levels; off treats all as high.
// - Bits 2..0 choose rising (1) or falling (0) pin edge; reset 1.
// - Handler state reads 00 main, 01 low, 10 high, 11 high over low.
// - Hardware sets event flags regardless of enables.
// - Flag bits 6..1 are hardware-set, software-cleared system events.
// - Bit 0 is a software request flag; hardware never sets it.
// - Summary bit 7 is read-only and clears when all pin-change bits clear.
// - Clock switch event gives no wake-up while asleep.
// - A selected edge on an external pin sets that pin's flag.
// - Wake request for any enabled event, independent of global enables.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module interrupt_global_control_status
  import intc_global_pkg::*;
#(
  parameter int PIN_CHANGE_W = 8
) (
  input  wire logic              hclk,             // System clock, 25 MHz.
  input  wire logic              hresetn,          // Asynchronous reset, active low.
  input  wire logic              clk_en,           // Freezes all state while low.
  input  wire logic              hsel,             // AHB slave select.
  input  wire logic [31:0]       haddr,            // AHB address.
  input  wire logic [1:0]        htrans,           // AHB transfer type.
  input  wire logic              hwrite,           // AHB write strobe.
  input  wire logic [2:0]        hsize,            // AHB size, word only.
  input  wire logic [31:0]       hwdata,           // AHB write data.
  input  wire logic              hready,           // AHB bus ready.
  output logic [31:0]            hrdata,           // AHB read data.
  output logic                   hreadyout,        // AHB slave ready.
  output logic                   hresp,            // AHB response, always OKAY.
  input  wire logic              vector_table_on,  // Configuration strap, caught after reset.
  input  wire logic [NUM_EXT-1:0] ext_pin,         // External interrupt pins, asynchronous.
  input  wire logic [6:1]        sys_event,        // One-cycle system event pulses.
  input  wire logic [PIN_CHANGE_W-1:0] pin_change_bits, // Pin-change flag levels.
  input  wire logic              cpu_enter_high,   // Core entered a high handler.
  input  wire logic              cpu_enter_low,    // Core entered a low handler.
  input  wire logic              cpu_return,       // Core left the current handler.
  input  wire logic              sleep_mode,       // Core is in Sleep.
  output logic                   cpu_irq_high,     // High priority request to core.
  output logic                   cpu_irq_low,      // Low priority request to core.
  output logic [SRC_W-1:0]       vector_number,    // Source chosen for the request.
  output logic [VT_W-1:0]        vector_entry,     // Address the core branches to.
  output logic                   wake_request,     // Wake-up request to the core.
  output logic                   irq               // Block event interrupt, level.
);

  // Refuse a pin-change group the summary cannot cover.
  if (PIN_CHANGE_W < 1 || PIN_CHANGE_W > 32) begin : g_check
    $error("PIN_CHANGE_W must lie between 1 and 32.");
  end

  // Lowest-numbered set source wins.
  function automatic logic [SRC_W-1:0] first_set(input logic [NUM_SRC-1:0] vec);
    logic [SRC_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Programmer-visible state.
  logic [7:0]         global_control;
  logic [7:0]         system_event_flags;
  logic [NUM_EXT-1:0] ext_pin_flag;
  logic [NUM_SRC-1:0] source_enable;
  logic [NUM_SRC-1:0] source_priority;
  logic [VT_W-1:0]    vector_table_base;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_enable;
  handler_state_type  handler_state;
  logic               vt_mode;
  logic               strap_taken;

  // Bus tracking.
  bus_phase_type      data_phase;
  logic               wr_pending;
  logic               rd_pending;

  // Pin synchronisers and edge history.
  logic [NUM_EXT-1:0] pin_meta;
  logic [NUM_EXT-1:0] pin_sync;
  logic [NUM_EXT-1:0] pin_prev;
  logic [NUM_EXT-1:0] pin_edge;

  // Field views of global control.
  wire logic               high_en = global_control[GC_HIGH_EN_BIT];
  wire logic               low_en  = global_control[GC_LOW_EN_BIT];
  wire logic               prio_on = global_control[GC_PRIO_BIT];
  wire logic [NUM_EXT-1:0] edge_sel = global_control[GC_EDGE_LSB +: NUM_EXT];

  // Bus decode.
  wire logic       addr_take = hsel & htrans[1] & hready;
  wire logic [7:0] wr_ofs    = data_phase.offset;
  wire logic       wr_now    = wr_pending;
  wire logic       wr_gc     = wr_now & (wr_ofs == OFS_GLOBAL_CONTROL);
  wire logic       wr_sef    = wr_now & (wr_ofs == OFS_SYSTEM_FLAGS);
  wire logic       wr_ena    = wr_now & (wr_ofs == OFS_SOURCE_ENABLE);
  wire logic       wr_pri    = wr_now & (wr_ofs == OFS_SOURCE_PRIORITY);
  wire logic       wr_pin    = wr_now & (wr_ofs == OFS_EXT_PIN_FLAGS);
  wire logic       wr_vtb    = wr_now & (wr_ofs == OFS_VECTOR_BASE);
  wire logic       wr_clr    = wr_now & (wr_ofs == OFS_IRQ_CLEAR);
  wire logic       wr_ien    = wr_now & (wr_ofs == OFS_IRQ_ENABLE);

  // Edge detection per external pin, on synchronised levels only.
  for (genvar p = 0; p < NUM_EXT; p++) begin : g_pin
    assign pin_edge[p] = edge_sel[p] ? (pin_sync[p] & ~pin_prev[p])
                                     : (~pin_sync[p] & pin_prev[p]);
  end

  // Pin-change summary follows the individual bits.
  // Summary is OR of pins.
  wire logic summary = |pin_change_bits;

  // Next values of the flag registers; hardware set wins over software clear.
  // Set regardless of enables.
  wire logic [7:0] sef_hw_set = {1'b0, sys_event, 1'b0} & SEF_HW_MASK;
  wire logic [7:0] sef_written = wr_sef ? (hwdata[7:0] & SEF_WRITE_MASK)
                                        : (system_event_flags & SEF_WRITE_MASK);
  wire logic [7:0] next_sef = ((sef_written | sef_hw_set) & ~(8'h01 << SEF_SUMMARY_BIT))
                              | ({7'h00, summary} << SEF_SUMMARY_BIT);
  wire logic [NUM_EXT-1:0] next_pin_flag =
      (wr_pin ? hwdata[NUM_EXT-1:0] : ext_pin_flag) | pin_edge;

  // Sources, pending set and priority split.
  wire logic [NUM_SRC-1:0] src_flag = {ext_pin_flag, system_event_flags};
  wire logic [NUM_SRC-1:0] pending  = src_flag & source_enable;
  // All sources high when levels are off.
  wire logic [NUM_SRC-1:0] high_map  = prio_on ? source_priority : {NUM_SRC{1'b1}};
  wire logic [NUM_SRC-1:0] high_pend = pending & high_map;
  wire logic [NUM_SRC-1:0] low_pend  = pending & ~high_map;

  // Handler state allows preemption only upward.
  wire logic in_main = (handler_state == ST_MAIN);
  wire logic in_low  = (handler_state == ST_LOW);

  wire logic take_high = high_en & (|high_pend) & (in_main | in_low);
  wire logic take_low  = prio_on & high_en & low_en & (|low_pend) & in_main & ~take_high;

  // Chosen source and its entry address.
  wire logic [SRC_W-1:0] chosen = first_set(take_high ? high_pend : low_pend);
  wire logic [VT_W-1:0] table_entry = vector_table_base + VT_W'({chosen, 1'b0});
  wire logic [VT_W-1:0] legacy_entry = (prio_on & take_low) ? LEGACY_LOW_VEC : FIXED_VECTOR;
  wire logic [VT_W-1:0] next_entry = vt_mode ? table_entry : legacy_entry;

  // Wake request ignores global enables; clock switch cannot wake from Sleep.
  // Clock switch masked asleep.
  wire logic [NUM_SRC-1:0] wake_mask = sleep_mode ? ~(NUM_SRC'(1) << SEF_CLKSW_BIT)
                                                  : {NUM_SRC{1'b1}};
  wire logic next_wake = |(pending & wake_mask);

  // Handler state code and next state.
  // State code read back.
  wire logic [1:0] state_code = (handler_state == ST_LOW)       ? CODE_LOW :
                                (handler_state == ST_HIGH_MAIN) ? CODE_HIGH_MAIN :
                                (handler_state == ST_HIGH_LOW)  ? CODE_HIGH_LOW : CODE_MAIN;
  handler_state_type next_state;
  always_comb begin
    next_state = handler_state;
    case (handler_state)
      ST_MAIN: begin
        if (cpu_enter_high || (cpu_enter_low && !prio_on)) begin
          next_state = ST_HIGH_MAIN;
        end else if (cpu_enter_low) begin
          next_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (cpu_enter_high) begin
          next_state = ST_HIGH_LOW;
        end else if (cpu_return) begin
          next_state = ST_MAIN;
        end
      end
      ST_HIGH_MAIN: begin
        if (cpu_return) begin
          next_state = ST_MAIN;
        end
      end
      ST_HIGH_LOW: begin
        if (cpu_return) begin
          next_state = ST_LOW;
        end
      end
      default: begin
        next_state = ST_MAIN;
      end
    endcase
  end

  // Block events and their sticky status; set wins over clear.
  wire logic [IRQ_W-1:0] ev_set;
  assign ev_set[EV_FLAG_SET]  = |sef_hw_set;
  assign ev_set[EV_PIN_EDGE]  = |pin_edge;
  assign ev_set[EV_HIGH_TAKE] = cpu_enter_high | (cpu_enter_low & ~prio_on);
  assign ev_set[EV_LOW_TAKE]  = cpu_enter_low & prio_on;
  wire logic [IRQ_W-1:0] ev_clr = wr_clr ? hwdata[IRQ_W-1:0] : '0;
  wire logic [IRQ_W-1:0] next_status = (irq_status & ~ev_clr) | ev_set;

  // Read mux for the word in the current data phase.
  // Low enable reads zero without levels.
  wire logic [7:0] gc_view = global_control & ~({7'h00, ~prio_on} << GC_LOW_EN_BIT);
  wire logic [31:0] read_word =
      (wr_ofs == OFS_GLOBAL_CONTROL)  ? {24'h000000, gc_view} :
      (wr_ofs == OFS_HANDLER_STATE)   ? {24'h000000, state_code, 6'h00} :
      (wr_ofs == OFS_SYSTEM_FLAGS)    ? {24'h000000, system_event_flags} :
      (wr_ofs == OFS_SOURCE_ENABLE)   ? {21'h000000, source_enable} :
      (wr_ofs == OFS_SOURCE_PRIORITY) ? {21'h000000, source_priority} :
      (wr_ofs == OFS_EXT_PIN_FLAGS)   ? {29'h00000000, ext_pin_flag} :
      (wr_ofs == OFS_VECTOR_BASE)     ? {8'h00, vector_table_base} :
      (wr_ofs == OFS_IRQ_STATUS)      ? {28'h0000000, irq_status} :
      (wr_ofs == OFS_IRQ_ENABLE)      ? {28'h0000000, irq_enable} : 32'h00000000;

  // Bus phase tracking; reads hold one wait state so data come from settled registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_phase <= '0;
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h00000000;
      hresp      <= 1'b0;
    end else if (clk_en) begin
      wr_pending <= addr_take & hwrite;
      rd_pending <= addr_take & ~hwrite;
      hreadyout  <= ~(addr_take & ~hwrite);
      if (addr_take) begin
        data_phase <= '{write: hwrite, offset: haddr[7:0]};
      end
      if (rd_pending) begin
        hrdata <= read_word;
      end
      hresp <= 1'b0;
    end
  end

  // Configuration strap caught once after reset release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vt_mode     <= 1'b0;
      strap_taken <= 1'b0;
    end else if (clk_en && !strap_taken) begin
      vt_mode     <= vector_table_on;
      strap_taken <= 1'b1;
    end
  end

  // Control registers written by software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_control    <= GC_RESET;
      source_enable     <= ENA_RESET;
      source_priority   <= PRIO_RESET;
      vector_table_base <= VT_RESET;
      irq_enable        <= '0;
    end else if (clk_en) begin
      if (wr_gc) begin
        global_control <= hwdata[7:0] & GC_WRITE_MASK;
      end
      if (wr_ena) begin
        source_enable <= hwdata[NUM_SRC-1:0];
      end
      if (wr_pri) begin
        source_priority <= hwdata[NUM_SRC-1:0];
      end
      if (wr_vtb) begin
        vector_table_base <= hwdata[VT_W-1:0];
      end
      if (wr_ien) begin
        irq_enable <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // Flags, handler state and event status.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_event_flags <= SEF_RESET;
      ext_pin_flag       <= '0;
      handler_state      <= ST_MAIN;
      irq_status         <= '0;
    end else if (clk_en) begin
      system_event_flags <= next_sef;
      ext_pin_flag       <= next_pin_flag;
      handler_state      <= next_state;
      irq_status         <= next_status;
    end
  end

  // External pin synchronisers and edge history.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else if (clk_en) begin
      pin_meta <= ext_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Registered requests to the core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_irq_high  <= 1'b0;
      cpu_irq_low   <= 1'b0;
      vector_number <= '0;
      vector_entry  <= FIXED_VECTOR;
      wake_request  <= 1'b0;
      irq           <= 1'b0;
    end else if (clk_en) begin
      cpu_irq_high  <= take_high;
      cpu_irq_low   <= take_low;
      vector_number <= chosen;
      vector_entry  <= next_entry;
      wake_request  <= next_wake;
      irq           <= |(next_status & irq_enable);
    end
  end

endmodule : interrupt_global_control_status
